// ### design/mcs_pkg.sv
package mcs_pkg;

	// ==========================================================
	// Spreading code
	localparam int CODE_W = 32;
	localparam int HALF_W = 16;
	localparam int SYM_W = 4;
	localparam int PTR_W = 4;
	// Chips c0..c31 of symbol 0, c0 in bit 0
	localparam logic [CODE_W-1:0] BASE_CODE = 32'h744A_C39B;
	// Odd chips inverted for symbols 8..15
	localparam logic [CODE_W-1:0] ODD_MASK = 32'hAAAA_AAAA;
	localparam logic [SYM_W-1:0] IDLE_SYMBOL = 4'h0;

	// ==========================================================
	// Pointer values
	localparam logic [PTR_W-1:0] EVEN_PTR_START = 4'hF;
	localparam logic [PTR_W-1:0] ODD_PTR_START = 4'hE;
	localparam logic [PTR_W-1:0] EVEN_PTR_LAST = 4'hE;

	// ==========================================================
	// Delimiter tracking
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] SFD_TARGET = 4'hB;
	localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

	// ==========================================================
	// Register map
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_SFD_BIT = 1;
	localparam int STAT_DONE_BIT = 2;
	localparam int STAT_CNT_LSB = 8;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_WAIT,
		ST_PULL,
		ST_LOAD_EVEN,
		ST_LOAD_ODD,
		ST_SHIFT_EVEN,
		ST_SHIFT_ODD,
		ST_ODD_FINAL,
		ST_FINISH
	} mcs_state_e;

	typedef struct packed {
		logic [HALF_W-1:0] even_chips;
		logic [HALF_W-1:0] odd_chips;
	} mcs_chips_s;

endpackage

// ### design/mcs_code_lookup.sv
`timescale 1ns/1ps
module mcs_code_lookup
	import mcs_pkg::*;
(
	input wire logic [SYM_W-1:0] symbol,	// Symbol from queue
	input wire logic sym_present,	// Symbol is valid
	output mcs_chips_s chips	// Even and odd chip words
);

	logic [SYM_W-1:0] sym_used;
	logic [CODE_W-1:0] rot_code;
	logic [CODE_W-1:0] full_code;

	// Idle input forces symbol 0 to stop switching
	assign sym_used = sym_present ? symbol : IDLE_SYMBOL;

	// ==========================================================
	// Symbol to 32-chip code
	always_comb begin
		unique case (sym_used[2:0])
			3'h0: rot_code = BASE_CODE;
			3'h1: rot_code = {BASE_CODE[27:0], BASE_CODE[31:28]};
			3'h2: rot_code = {BASE_CODE[23:0], BASE_CODE[31:24]};
			3'h3: rot_code = {BASE_CODE[19:0], BASE_CODE[31:20]};
			3'h4: rot_code = {BASE_CODE[15:0], BASE_CODE[31:16]};
			3'h5: rot_code = {BASE_CODE[11:0], BASE_CODE[31:12]};
			3'h6: rot_code = {BASE_CODE[7:0], BASE_CODE[31:8]};
			3'h7: rot_code = {BASE_CODE[3:0], BASE_CODE[31:4]};
		endcase
		full_code = sym_used[3] ? (rot_code ^ ODD_MASK) : rot_code;
	end

	// ==========================================================
	// Split into even and odd chips
	for (genvar k = 0; k < HALF_W; k++) begin : g_split
		assign chips.even_chips[k] = full_code[2*k];
		assign chips.odd_chips[k] = full_code[2*k+1];
	end

endmodule // mcs_code_lookup

// ### design/mcs_pull_counter.sv
`timescale 1ns/1ps
module mcs_pull_counter
	import mcs_pkg::*;
(
	input wire logic clock,	// System clock
	input wire logic sys_rst,	// Async reset, active high
	input wire logic clear,	// Synchronous clear
	input wire logic pull,	// Queue pull this cycle
	input wire logic in_load_odd,	// Machine in odd-load state
	output logic sfd_sent,	// Delimiter sent pulse
	output logic [CNT_W-1:0] count	// Current pull count
);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	// ==========================================================
	// Count pulls, saturating past the target
	always_comb begin
		nxt_cnt = cnt_ff;
		if (clear) begin
			nxt_cnt = CNT_RESET;
		end else if (pull && (cnt_ff != SFD_TARGET + 4'h1)) begin
			nxt_cnt = cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= CNT_RESET;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign sfd_sent = (cnt_ff == SFD_TARGET) && in_load_odd;
	assign count = cnt_ff;

endmodule // mcs_pull_counter

// ### design/mcs_spreader.sv
// Functional notes
// - Split code into even and odd 16-chip words
// - Even MSK chip is even xor odd
// - Odd MSK chip inverted, uses next even
// - Start waits for data, then presets pointers
// - Pull state pulls once, odd pointer advances
// - Even-load captures even chips, wraps pointer
// - Odd-load captures odd chips, wraps pointer
// - Even-shift advances, then shift, pull or odd-final
// - Odd-shift advances odd pointer, returns
// - Odd-final advances odd pointer, then finish
// - Finish pulses done one cycle, goes idle
// - Chip output is selected bits xor invert
// - Delimiter pulse at count 11 in odd-load
// - Pull counter saturates at target plus one
// - Lookup maps symbol by case to codes
// - Absent symbol looks up symbol zero
// - Done marks last packet chip sent
`timescale 1ns/1ps
module mcs_spreader
	import mcs_pkg::*;
(
	input wire logic clock,	// System clock, 20 MHz
	input wire logic sys_rst,	// Async reset, active high
	input wire logic [11:0] paddr,	// APB address
	input wire logic psel,	// APB select
	input wire logic penable,	// APB enable
	input wire logic pwrite,	// APB write
	input wire logic [31:0] pwdata,	// APB write data
	output logic [31:0] prdata,	// APB read data
	output logic pready,	// APB ready
	output logic pslverr,	// APB error
	input wire logic [SYM_W-1:0] queue_symbol,	// Symbol from queue
	input wire logic queue_empty,	// Queue empty flag
	output logic queue_pull,	// Queue pull request
	output logic chip_out,	// Serial chip stream
	output logic sfd_sent,	// Delimiter sent pulse
	output logic done	// Packet done pulse
);

	// ==========================================================
	// Declarations
	mcs_state_e state_ff;
	mcs_state_e nxt_state;
	logic [PTR_W-1:0] even_ptr_ff;
	logic [PTR_W-1:0] nxt_even_ptr;
	logic [PTR_W-1:0] odd_ptr_ff;
	logic [PTR_W-1:0] nxt_odd_ptr;
	logic [HALF_W-1:0] even_reg_ff;
	logic [HALF_W-1:0] nxt_even_reg;
	logic [HALF_W-1:0] odd_reg_ff;
	logic [HALF_W-1:0] nxt_odd_reg;
	logic chip_inv;
	logic chip_ff;
	logic nxt_chip;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic sfd_seen_ff;
	logic nxt_sfd_seen;
	logic done_seen_ff;
	logic nxt_done_seen;
	logic start_req;
	logic start_idle;
	logic clear_req;
	logic wr_access;
	logic rd_setup;
	logic hit_ctrl;
	logic hit_status;
	logic sym_present;
	logic sfd_pulse;
	logic [CNT_W-1:0] pull_count;
	logic [31:0] status_word;
	mcs_chips_s chips;

	// ==========================================================
	// APB slave, zero wait states
	assign hit_ctrl = (paddr == CTRL_OFFSET);
	assign hit_status = (paddr == STATUS_OFFSET);
	assign wr_access = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_ctrl && !hit_status;
	assign prdata = prdata_ff;

	assign start_req = wr_access && hit_ctrl && pwdata[CTRL_START_BIT];
	// A start outside idle is ignored and must not zero the pull count
	assign start_idle = start_req && (state_ff == ST_IDLE);
	// Software clear between packets
	assign clear_req = wr_access && hit_ctrl && pwdata[CTRL_CLEAR_BIT];

	always_comb begin
		status_word = WORD_ZERO;
		status_word[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
		status_word[STAT_SFD_BIT] = sfd_seen_ff;
		status_word[STAT_DONE_BIT] = done_seen_ff;
		status_word[STAT_CNT_LSB +: CNT_W] = pull_count;
	end

	always_comb begin
		nxt_prdata = prdata_ff;
		if (rd_setup) begin
			nxt_prdata = hit_status ? status_word : WORD_ZERO;
		end
	end

	// Read data stands until the next read setup
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_ff <= WORD_ZERO;
		end else begin
			prdata_ff <= nxt_prdata;
		end
	end

	// Sticky event flags, write one to clear, set wins
	always_comb begin
		nxt_sfd_seen = sfd_seen_ff;
		nxt_done_seen = done_seen_ff;
		if (wr_access && hit_status && pwdata[STAT_SFD_BIT]) begin
			nxt_sfd_seen = 1'b0;
		end
		if (wr_access && hit_status && pwdata[STAT_DONE_BIT]) begin
			nxt_done_seen = 1'b0;
		end
		if (sfd_pulse) begin
			nxt_sfd_seen = 1'b1;
		end
		if (done) begin
			nxt_done_seen = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sfd_seen_ff <= 1'b0;
			done_seen_ff <= 1'b0;
		end else begin
			sfd_seen_ff <= nxt_sfd_seen;
			done_seen_ff <= nxt_done_seen;
		end
	end

	// ==========================================================
	// Code lookup
	assign sym_present = (state_ff == ST_LOAD_EVEN) || (state_ff == ST_LOAD_ODD);

	mcs_code_lookup u_lookup (
		.symbol(queue_symbol),
		.sym_present(sym_present),
		.chips(chips)
	);

	// ==========================================================
	// Transmit state machine
	always_comb begin
		nxt_state = state_ff;
		nxt_even_ptr = even_ptr_ff;
		nxt_odd_ptr = odd_ptr_ff;
		nxt_even_reg = even_reg_ff;
		nxt_odd_reg = odd_reg_ff;
		if (clear_req) begin
			nxt_state = ST_IDLE;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (start_req) begin
						nxt_state = ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (!queue_empty) begin
						nxt_state = ST_PULL;
						// Presets place chips 30 and 31 in the two load states
						nxt_even_ptr = EVEN_PTR_START;
						nxt_odd_ptr = ODD_PTR_START;
					end
				end
				ST_PULL: begin
					nxt_odd_ptr = odd_ptr_ff + 4'h1;
					nxt_state = ST_LOAD_EVEN;
				end
				ST_LOAD_EVEN: begin
					// Queue head holds the pulled symbol here and in odd-load
					nxt_even_reg = chips.even_chips;
					nxt_even_ptr = even_ptr_ff + 4'h1;
					nxt_state = ST_LOAD_ODD;
				end
				ST_LOAD_ODD: begin
					// Odd word of the old symbol is replaced only after chip 31
					nxt_odd_reg = chips.odd_chips;
					nxt_odd_ptr = odd_ptr_ff + 4'h1;
					nxt_state = ST_SHIFT_EVEN;
				end
				ST_SHIFT_EVEN: begin
					nxt_even_ptr = even_ptr_ff + 4'h1;
					if (even_ptr_ff < EVEN_PTR_LAST) begin
						nxt_state = ST_SHIFT_ODD;
					end else if (!queue_empty) begin
						nxt_state = ST_PULL;
					end else begin
						nxt_state = ST_ODD_FINAL;
					end
				end
				ST_SHIFT_ODD: begin
					nxt_odd_ptr = odd_ptr_ff + 4'h1;
					nxt_state = ST_SHIFT_EVEN;
				end
				ST_ODD_FINAL: begin
					nxt_odd_ptr = odd_ptr_ff + 4'h1;
					nxt_state = ST_FINISH;
				end
				ST_FINISH: begin
					nxt_state = ST_IDLE;
				end
				default: begin
					nxt_state = ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Chip combining
	// Pointers equal: even MSK chip; pointers apart outside idle and wait: odd MSK chip, inverted
	// Built from next values so chip_out comes straight from a flip-flop
	always_comb begin
		chip_inv = 1'b0;
		if (nxt_state != ST_IDLE && nxt_state != ST_WAIT) begin
			chip_inv = (nxt_even_ptr != nxt_odd_ptr);
		end
		nxt_chip = (nxt_even_reg[nxt_even_ptr] ^ nxt_odd_reg[nxt_odd_ptr]) ^ chip_inv;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			chip_ff <= 1'b0;
		end else begin
			chip_ff <= nxt_chip;
		end
	end

	// Machine registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= ST_IDLE;
			even_ptr_ff <= EVEN_PTR_START;
			odd_ptr_ff <= ODD_PTR_START;
			even_reg_ff <= '0;
			odd_reg_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			even_ptr_ff <= nxt_even_ptr;
			odd_ptr_ff <= nxt_odd_ptr;
			even_reg_ff <= nxt_even_reg;
			odd_reg_ff <= nxt_odd_reg;
		end
	end

	// ==========================================================
	// Outputs
	assign chip_out = chip_ff;
	assign queue_pull = (state_ff == ST_PULL);
	// Last chip of the packet leaves during the finish cycle, with done high
	assign done = (state_ff == ST_FINISH);

	mcs_pull_counter u_count (
		.clock(clock),
		.sys_rst(sys_rst),
		.clear(clear_req || start_idle),
		.pull(queue_pull),
		.in_load_odd(state_ff == ST_LOAD_ODD),
		.sfd_sent(sfd_pulse),
		.count(pull_count)
	);

	assign sfd_sent = sfd_pulse;

endmodule // mcs_spreader

// ### verif/mcs_spreader_asserts.sv
`timescale 1ns/1ps
module mcs_spreader_asserts
	import mcs_pkg::*;
(
	input wire logic clock,	// Clock
	input wire logic sys_rst,	// Reset
	input wire logic [11:0] paddr,	// Address
	input wire logic psel,	// Select
	input wire logic penable,	// Enable
	input wire logic pready,	// Ready
	input wire logic pslverr,	// Error
	input wire logic queue_empty,	// Empty flag
	input wire logic queue_pull,	// Pull
	input wire logic sfd_sent,	// Delimiter pulse
	input wire logic done	// Done pulse
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// Queue side
	property p_pull_gap; queue_pull |=> !queue_pull [*8]; endproperty
	a_pull_gap: assert property (p_pull_gap) else $error("pull repeated too soon");
	property p_pull_data; queue_pull |-> !$past(queue_empty); endproperty
	a_pull_data: assert property (p_pull_data) else $error("pull from empty queue");
	property p_next; queue_pull |-> ##[20:40] (queue_pull || done); endproperty
	a_next: assert property (p_next) else $error("no pull or done after symbol");
	property p_sfd; sfd_sent |-> $past(queue_pull, 2); endproperty
	a_sfd: assert property (p_sfd) else $error("delimiter pulse not in odd load");
	property p_done_one; done |=> !done; endproperty
	a_done_one: assert property (p_done_one) else $error("done longer than one cycle");
	property p_done_idle; done |=> !queue_pull [*8]; endproperty
	a_done_idle: assert property (p_done_idle) else $error("activity after done");
	property p_rst; disable iff (1'b0) sys_rst |-> !queue_pull && !sfd_sent && !done; endproperty
	a_rst: assert property (p_rst) else $error("outputs active in reset");
	// ==========================================================
	// Register bus
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready in access");
	property p_err; psel && penable |-> pslverr == !(paddr == CTRL_OFFSET || paddr == STATUS_OFFSET); endproperty
	a_err: assert property (p_err) else $error("wrong error response");
endmodule // mcs_spreader_asserts

bind mcs_spreader mcs_spreader_asserts chk_u (.clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .queue_empty(queue_empty),
	.queue_pull(queue_pull), .sfd_sent(sfd_sent), .done(done));

// ### verif/mcs_queue_model.sv
`timescale 1ns/1ps
module mcs_queue_model
	import mcs_pkg::*;
(
	input wire logic clock,	// Clock
	input wire logic queue_pull,	// Pull
	input wire logic [7:0] n_avail,	// Symbols on offer
	output logic [SYM_W-1:0] queue_symbol,	// Head symbol
	output logic queue_empty	// Nothing left
);
	logic [SYM_W-1:0] mem [256];
	logic [7:0] ptr = 8'h00;
	logic [1:0] age = 2'h3;
	always @(posedge clock) begin
		if (queue_pull) begin
			ptr <= ptr + 8'h01;
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	// Head holds only two cycles after a pull, then shows garbage
	assign queue_symbol = (age < 2'h2) ? mem[ptr - 8'h01] : ~mem[ptr - 8'h01];
	assign queue_empty = (ptr >= n_avail);
endmodule // mcs_queue_model

// ### verif/mcs_spreader_tb.sv
`timescale 1ns/1ps
module mcs_spreader_tb;
	import mcs_pkg::*;
	logic clock = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, queue_empty, queue_pull, chip_out, sfd_sent, done;
	logic [SYM_W-1:0] queue_symbol;
	logic [7:0] n_avail = 8'h00, sfd_ptr;
	int miscompares = 0, n_compared = 0, sfd_n = 0, done_n = 0, cyc = 0;
	always #25 clock = ~clock;
	mcs_spreader dut_u (.clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.queue_symbol(queue_symbol), .queue_empty(queue_empty), .queue_pull(queue_pull),
		.chip_out(chip_out), .sfd_sent(sfd_sent), .done(done));
	mcs_queue_model q_u (.clock(clock), .queue_pull(queue_pull), .n_avail(n_avail),
		.queue_symbol(queue_symbol), .queue_empty(queue_empty));
	task summarize;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (sfd_sent === 1'h1) begin
			sfd_n++;
			sfd_ptr = q_u.ptr;
		end
		if (done === 1'h1)
			done_n++;
		if (cyc == 5000) begin
			miscompares++;
			summarize();
		end
	end
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		@(posedge clock);
		while (pready !== 1'h1)
			@(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	function automatic logic [3:0] sym_of(int i);
		return i < 8 ? 4'h0 : i == 8 ? 4'h5 : i == 9 ? 4'hE : 4'(i - 10);
	endfunction
	function automatic logic [31:0] code_of(logic [3:0] s);
		logic [31:0] b;
		b = BASE_CODE;
		for (int r = 0; r < s[2:0]; r++)
			b = {b[27:0], b[31:28]};
		return s[3] ? b ^ ODD_MASK : b;
	endfunction
	// Follows the serial stream from the first chip of symbol first
	task packet(input int first, input int n);
		logic [31:0] c, cn;
		logic m;
		int k;
		while (queue_pull !== 1'h1) begin
			@(posedge clock);
			#1;
		end
		repeat (2) @(posedge clock);
		for (int j = 0; j < 32 * n - 1; j++) begin
			@(posedge clock);
			#1;
			k = j % 32;
			c = code_of(sym_of(first + j / 32));
			cn = code_of(sym_of(first + j / 32 + 1));
			// One-bit target keeps the inversion from spreading into upper bits
			m = k % 2 ? ~(c[k] ^ (k == 31 ? cn[0] : c[k + 1])) : c[k] ^ c[k + 1];
			check("chip", chip_out, m);
		end
		repeat (4) @(posedge clock);
	endtask
	initial begin
		repeat (6) @(posedge clock);
		sys_rst <= 1'h0;
		for (int i = 0; i < 256; i++)
			q_u.mem[i] = sym_of(i);
		apb(1'h0, STATUS_OFFSET, WORD_ZERO);
		check("reset status", rd, WORD_ZERO);
		apb(1'h0, CTRL_OFFSET, WORD_ZERO);
		check("ctrl", rd, WORD_ZERO);
		apb(1'h0, 12'h008, WORD_ZERO);
		check("unmapped", {rd[30:0], err}, 32'h0000_0001);
		apb(1'h1, CTRL_OFFSET, 32'h0000_0001);
		repeat (10) @(posedge clock);
		apb(1'h0, STATUS_OFFSET, WORD_ZERO);
		check("waiting", rd, 32'h0000_0001);
		n_avail <= 8'h1A;
		packet(0, 26);
		check("sfd count", sfd_n, 32'h0000_0001);
		check("sfd pull", sfd_ptr, 32'h0000_000B);
		check("done count", done_n, 32'h0000_0001);
		apb(1'h0, STATUS_OFFSET, WORD_ZERO);
		check("status", rd, 32'h0000_0C06);
		apb(1'h1, STATUS_OFFSET, 32'h0000_0006);
		apb(1'h1, CTRL_OFFSET, 32'h0000_0002);
		apb(1'h0, STATUS_OFFSET, WORD_ZERO);
		check("cleared", rd, WORD_ZERO);
		n_avail <= 8'h1D;
		apb(1'h1, CTRL_OFFSET, 32'h0000_0001);
		packet(26, 3);
		check("short sfd", sfd_n, 32'h0000_0001);
		check("short done", done_n, 32'h0000_0002);
		apb(1'h0, STATUS_OFFSET, WORD_ZERO);
		check("short status", rd, 32'h0000_0304);
		summarize();
	end
endmodule // mcs_spreader_tb
